// *** rtl/sspt_params.svh ***
`ifndef SSPT_PARAMS_SVH
`define SSPT_PARAMS_SVH
// Register addresses
`define SSPT_ADDR_CTRL 3'h0
`define SSPT_ADDR_BAUD 3'h1
`define SSPT_ADDR_TXD 3'h2
`define SSPT_ADDR_TXA 3'h3
`define SSPT_ADDR_RXD 3'h4
`define SSPT_ADDR_STAT 3'h5
`define SSPT_ADDR_PINS 3'h6
// Control fields; word select in bits 2..0
`define SSPT_CTL_TX_EN 3
`define SSPT_CTL_RX_EN 4
`define SSPT_CTL_WAKE_ADDR 5
`define SSPT_CTL_RWU 6
`define SSPT_CTL_WOR 7
`define SSPT_CTL_CKP 8
`define SSPT_CTL_TCS 9
`define SSPT_CTL_RCS 10
`define SSPT_CTL_TMR_EN 11
// Status register fields
`define SSPT_ST_TX_EMPTY 0
`define SSPT_ST_TX_IDLE 1
`define SSPT_ST_RX_FULL 2
`define SSPT_ST_OVERRUN 3
`define SSPT_ST_PAR_ERR 4
`define SSPT_ST_FRM_ERR 5
`define SSPT_ST_ADDR_BIT 6
`define SSPT_ST_IDLE 7
`define SSPT_ST_TIMER 8
// Reset values
`define SSPT_CTRL_RESET 12'h000
`define SSPT_BAUD_RESET 12'h001
`define SSPT_PINS_RESET 3'h0
// Timing in 16x ticks
`define SSPT_OVS_LAST 4'hF
`define SSPT_OVS_MID 4'h7
`define SSPT_IDLE_TICKS 8'hA0
`endif

// *** rtl/sspt_pkg.sv ***
package sspt_pkg;
   typedef enum logic [2:0] {
      SSPT_WS_SYNC = 3'h0,
      SSPT_WS_ASYNC10 = 3'h1,
      SSPT_WS_EVEN = 3'h2,
      SSPT_WS_ODD = 3'h3,
      SSPT_WS_MULTI = 3'h4
   } sspt_format_type;
   typedef enum {SSPT_TX_IDLE, SSPT_TX_ASYNC, SSPT_TX_SYNC} sspt_tx_state_type;
   typedef enum {SSPT_RX_IDLE, SSPT_RX_START, SSPT_RX_DATA} sspt_rx_state_type;
endpackage : sspt_pkg

// *** rtl/sspt_serial_port.sv ***
`timescale 1ns/1ps
`include "sspt_params.svh"

// Overview of operation
// - Independent transmitter and receiver.
// - Baud generator clocks both sections; doubles as timer.
// - Word select 000: 8-bit synchronous shift register.
// - Ten-bit frame: start, eight data, stop.
// - Eleven-bit frames with even or odd parity.
// - Eleven-bit multidrop frame, ninth bit data/address.
// - Word select picks sync, async, parity or multidrop.
// - Sync transmit and receive share one clock.
// - Clock sources 0: sync master drives serial clock.
// - Clock sources 1: sync slave clocked from pin.
// - Missed sync clock misaligns silently; reset realigns.
// - Async engines run at sixteen times bit rate.
// - Async receiver aligns on each start bit.
// - Multidrop data write sends ninth bit zero.
// - Wired-OR releases the line instead of driving high.
// - Idle line wakes a suspended receiver.
// - Address wakeup only on ninth bit one.
// - Port held in reset while no pin is serial.
// - Polarity clear: receive on rise, transmit on fall.
// - Pins to GPIO: stop, status reset except timer flag, control kept.
module sspt_serial_port #(
   parameter int BAUD_W = 12
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_rxd,
   output logic o_txd,
   output logic o_txd_oe,
   input wire logic i_sclk,
   output logic o_sclk,
   output logic o_sclk_oe,
   output logic o_timer_event
);
   import sspt_pkg::*;

   //--------------------
   // Declarations
   //--------------------
   logic [11:0] ctrl, next_ctrl;
   logic [BAUD_W-1:0] baud_div, next_baud_div, baud_cnt, next_baud_cnt;
   logic [2:0] pins, next_pins;
   logic [7:0] tx_buf, next_tx_buf, rx_buf, next_rx_buf;
   logic tx_addr, next_tx_addr, tx_full, next_tx_full;
   logic rx_full, next_rx_full, ovr, next_ovr, perr, next_perr;
   logic ferr, next_ferr, rx_b9, next_rx_b9, idle_f, next_idle_f, tmr_f, next_tmr_f;
   logic [15:0] next_rdata;
   logic port_rst, tick, sync_mode, master, fmt10, rxd;
   logic sclk_lvl, next_sclk_lvl, sclk_prev, next_sclk_prev, rise, fall;
   sspt_tx_state_type tx_st, next_tx_st;
   logic [10:0] tx_sh, next_tx_sh;
   logic [3:0] tx_ph, next_tx_ph, tx_bits, next_tx_bits;
   logic tx_take;
   sspt_rx_state_type rx_st, next_rx_st;
   logic [9:0] rx_sh, next_rx_sh, rx_fin;
   logic [3:0] rx_ph, next_rx_ph, rx_bits, next_rx_bits;
   logic [7:0] idle_cnt, next_idle_cnt;
   logic idle_armed, next_idle_armed;
   logic rx_store, rx_idle_evt, rx_wake, rx_pe, rx_fe, rx_b9_evt;
   logic [7:0] rx_byte;

   //--------------------
   // Shared decode
   //--------------------
   assign port_rst = ~|pins;
   assign sync_mode = (ctrl[2:0] == SSPT_WS_SYNC);
   assign fmt10 = (ctrl[2:0] == SSPT_WS_ASYNC10) || (ctrl[2:0] > SSPT_WS_MULTI);
   assign master = ~ctrl[`SSPT_CTL_TCS] & ~ctrl[`SSPT_CTL_RCS];
   assign rxd = pins[0] ? i_rxd : 1'b1; // Unassigned pin reads as an idle line
   assign tick = (baud_cnt == '0);

   //--------------------
   // Baud generator, timer and serial clock
   //--------------------
   // Master edges from our own clock, slave edges from the pin
   always_comb begin
      next_baud_cnt = tick ? baud_div : baud_cnt - 1'b1;
      next_sclk_prev = i_sclk ^ ctrl[`SSPT_CTL_CKP];
      next_sclk_lvl = 1'b0;
      if (master && tx_st == SSPT_TX_SYNC && !port_rst) begin
         next_sclk_lvl = tick ? ~sclk_lvl : sclk_lvl;
      end
      if (master) begin
         rise = tick & ~sclk_lvl & (tx_st == SSPT_TX_SYNC);
         fall = tick & sclk_lvl;
      end else begin
         rise = next_sclk_prev & ~sclk_prev;
         fall = ~next_sclk_prev & sclk_prev;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         baud_cnt <= '0;
         sclk_lvl <= 1'b0;
         sclk_prev <= 1'b0;
      end else begin
         baud_cnt <= next_baud_cnt;
         sclk_lvl <= next_sclk_lvl;
         sclk_prev <= next_sclk_prev;
      end
   end

   // Timer ticks whatever the pin setting
   assign o_timer_event = ctrl[`SSPT_CTL_TMR_EN] & tick;
   assign o_sclk = sclk_lvl ^ ctrl[`SSPT_CTL_CKP];
   assign o_sclk_oe = pins[2] & sync_mode & master;
   assign o_txd = tx_sh[0];
   // Wired-OR only pulls low; idle senders never fight
   assign o_txd_oe = pins[1] & (ctrl[`SSPT_CTL_WOR] ? ~tx_sh[0] : 1'b1);

   //--------------------
   // Transmitter
   //--------------------
   always_comb begin
      next_tx_st = tx_st;
      next_tx_sh = tx_sh;
      next_tx_ph = tx_ph;
      next_tx_bits = tx_bits;
      tx_take = 1'b0;
      case (tx_st)
         SSPT_TX_IDLE: begin
            next_tx_sh = 11'h7FF;
            if (tx_full && ctrl[`SSPT_CTL_TX_EN]) begin
               tx_take = 1'b1;
               next_tx_ph = 4'h0;
               if (sync_mode) begin
                  next_tx_st = SSPT_TX_SYNC;
                  next_tx_sh = {3'h7, tx_buf};
                  next_tx_bits = 4'h8;
               end else begin
                  next_tx_st = SSPT_TX_ASYNC;
                  next_tx_bits = fmt10 ? 4'hA : 4'hB;
                  case (ctrl[2:0])
                     SSPT_WS_EVEN: next_tx_sh = {1'b1, ^tx_buf, tx_buf, 1'b0};
                     SSPT_WS_ODD: next_tx_sh = {1'b1, ~^tx_buf, tx_buf, 1'b0};
                     SSPT_WS_MULTI: next_tx_sh = {1'b1, tx_addr, tx_buf, 1'b0};
                     default: next_tx_sh = {2'h3, tx_buf, 1'b0};
                  endcase
               end
            end
         end
         SSPT_TX_ASYNC: begin
            if (tick) begin
               next_tx_ph = tx_ph + 1'b1;
               if (tx_ph == `SSPT_OVS_LAST) begin
                  next_tx_sh = {1'b1, tx_sh[10:1]};
                  next_tx_bits = tx_bits - 1'b1;
                  if (tx_bits == 4'h1) begin
                     next_tx_st = SSPT_TX_IDLE;
                  end
               end
            end
         end
         SSPT_TX_SYNC: begin
            // Shared edges keep both in step
            if (fall) begin
               next_tx_sh = {1'b1, tx_sh[10:1]};
            end
            if (rise) begin
               next_tx_bits = tx_bits - 1'b1;
               if (tx_bits == 4'h1) begin
                  next_tx_st = SSPT_TX_IDLE;
               end
            end
         end
         default: next_tx_st = SSPT_TX_IDLE;
      endcase
      if (port_rst) begin
         next_tx_st = SSPT_TX_IDLE;
         next_tx_sh = 11'h7FF;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         tx_st <= SSPT_TX_IDLE;
         tx_sh <= 11'h7FF;
         tx_ph <= 4'h0;
         tx_bits <= 4'h0;
      end else begin
         tx_st <= next_tx_st;
         tx_sh <= next_tx_sh;
         tx_ph <= next_tx_ph;
         tx_bits <= next_tx_bits;
      end
   end

   //--------------------
   // Receiver
   //--------------------
   always_comb begin
      next_rx_st = rx_st;
      next_rx_sh = rx_sh;
      next_rx_ph = rx_ph;
      next_rx_bits = rx_bits;
      next_idle_cnt = idle_cnt;
      next_idle_armed = idle_armed;
      rx_store = 1'b0;
      rx_idle_evt = 1'b0;
      rx_wake = 1'b0;
      rx_pe = 1'b0;
      rx_fe = 1'b0;
      rx_b9_evt = 1'b0;
      rx_byte = rx_sh[9:2];
      rx_fin = next_rx_sh;
      if (sync_mode) begin
         // No framing: a lost edge slips the byte
         next_rx_st = SSPT_RX_IDLE;
         if (rise && ctrl[`SSPT_CTL_RX_EN]) begin
            next_rx_sh = {rxd, rx_sh[9:1]};
            next_rx_bits = rx_bits + 1'b1;
            if (rx_bits == 4'h7) begin
               next_rx_bits = 4'h0;
               rx_store = 1'b1;
               rx_byte = next_rx_sh[9:2];
            end
         end
      end else begin
         case (rx_st)
            SSPT_RX_IDLE: begin
               if (!rxd) begin
                  next_rx_st = SSPT_RX_START;
                  next_rx_ph = 4'h0;
                  next_idle_cnt = 8'h00;
                  next_idle_armed = 1'b1;
               end else if (tick && idle_armed) begin
                  next_idle_cnt = idle_cnt + 1'b1;
                  if (idle_cnt == `SSPT_IDLE_TICKS) begin
                     rx_idle_evt = 1'b1;
                     next_idle_armed = 1'b0;
                  end
               end
            end
            SSPT_RX_START: begin
               if (tick) begin
                  next_rx_ph = rx_ph + 1'b1;
                  if (rx_ph == `SSPT_OVS_MID) begin
                     // A glitch shorter than half a bit is not a start bit
                     next_rx_st = rxd ? SSPT_RX_IDLE : SSPT_RX_DATA;
                     next_rx_ph = 4'h0;
                     next_rx_bits = 4'h0;
                  end
               end
            end
            SSPT_RX_DATA: begin
               if (tick) begin
                  next_rx_ph = rx_ph + 1'b1;
                  if (rx_ph == `SSPT_OVS_LAST) begin
                     next_rx_sh = {rxd, rx_sh[9:1]};
                     next_rx_bits = rx_bits + 1'b1;
                     if (next_rx_bits == (fmt10 ? 4'h9 : 4'hA)) begin
                        next_rx_st = SSPT_RX_IDLE;
                        next_rx_bits = 4'h0;
                        rx_fin = fmt10 ? {next_rx_sh[9], 1'b0, next_rx_sh[8:1]} : next_rx_sh;
                        rx_fe = ~rx_fin[9];
                        rx_b9_evt = rx_fin[8];
                        if (ctrl[2:0] == SSPT_WS_EVEN) begin
                           rx_pe = rx_fin[8] != ^rx_fin[7:0];
                        end else if (ctrl[2:0] == SSPT_WS_ODD) begin
                           rx_pe = rx_fin[8] != ~^rx_fin[7:0];
                        end
                        rx_wake = ctrl[`SSPT_CTL_WAKE_ADDR] && ctrl[2:0] == SSPT_WS_MULTI && rx_fin[8];
                        rx_store = ctrl[`SSPT_CTL_RX_EN] && (!ctrl[`SSPT_CTL_RWU] || rx_wake);
                     end
                  end
               end
            end
            default: next_rx_st = SSPT_RX_IDLE;
         endcase
         rx_byte = rx_fin[7:0];
      end
      if (!ctrl[`SSPT_CTL_RX_EN]) begin
         rx_store = 1'b0;
      end
      if (port_rst) begin
         next_rx_st = SSPT_RX_IDLE;
         next_rx_bits = 4'h0;
         next_idle_cnt = 8'h00;
         rx_store = 1'b0;
         rx_idle_evt = 1'b0;
         rx_wake = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         rx_st <= SSPT_RX_IDLE;
         rx_sh <= 10'h000;
         rx_ph <= 4'h0;
         rx_bits <= 4'h0;
         idle_cnt <= 8'h00;
         idle_armed <= 1'b1;
      end else begin
         rx_st <= next_rx_st;
         rx_sh <= next_rx_sh;
         rx_ph <= next_rx_ph;
         rx_bits <= next_rx_bits;
         idle_cnt <= next_idle_cnt;
         idle_armed <= next_idle_armed;
      end
   end

   //--------------------
   // Register file
   //--------------------
   // Hardware sets beat software clears
   always_comb begin
      logic rd_rx, rd_st;
      rd_rx = i_rd && i_addr == `SSPT_ADDR_RXD;
      rd_st = i_rd && i_addr == `SSPT_ADDR_STAT;
      next_ctrl = ctrl;
      next_baud_div = baud_div;
      next_pins = pins;
      next_tx_buf = tx_buf;
      next_tx_addr = tx_addr;
      next_tx_full = tx_full & ~tx_take;
      next_rx_buf = rx_store ? rx_byte : rx_buf;
      next_rx_b9 = rx_store ? rx_b9_evt : rx_b9;
      next_rx_full = (rx_full & ~rd_rx) | rx_store;
      next_ovr = (ovr & ~rd_st) | (rx_store & rx_full & ~rd_rx);
      next_perr = (perr & ~rd_st) | (rx_store & rx_pe);
      next_ferr = (ferr & ~rd_st) | (rx_store & rx_fe);
      next_idle_f = (idle_f & ~rd_st) | rx_idle_evt;
      next_tmr_f = (tmr_f & ~rd_st) | o_timer_event;
      if (i_wr) begin
         case (i_addr)
            `SSPT_ADDR_CTRL: next_ctrl = i_wdata[11:0];
            `SSPT_ADDR_BAUD: next_baud_div = i_wdata[BAUD_W-1:0];
            `SSPT_ADDR_PINS: next_pins = i_wdata[2:0];
            `SSPT_ADDR_TXD: begin
               next_tx_buf = i_wdata[7:0];
               next_tx_addr = 1'b0;
               next_tx_full = 1'b1;
            end
            `SSPT_ADDR_TXA: begin
               next_tx_buf = i_wdata[7:0];
               next_tx_addr = 1'b1;
               next_tx_full = 1'b1;
            end
            default: next_pins = pins;
         endcase
      end
      // Wakeup clear of suspend beats a software write
      if ((rx_idle_evt && !ctrl[`SSPT_CTL_WAKE_ADDR]) || rx_wake) begin
         next_ctrl[`SSPT_CTL_RWU] = 1'b0;
      end
      // Status resets except the timer flag, control survives
      if (port_rst) begin
         next_tx_full = 1'b0;
         next_rx_full = 1'b0;
         next_ovr = 1'b0;
         next_perr = 1'b0;
         next_ferr = 1'b0;
         next_idle_f = 1'b0;
         next_rx_b9 = 1'b0;
      end
      next_rdata = 16'h0000;
      if (i_rd) begin
         case (i_addr)
            `SSPT_ADDR_CTRL: next_rdata = {4'h0, ctrl};
            `SSPT_ADDR_BAUD: next_rdata = 16'(baud_div);
            `SSPT_ADDR_PINS: next_rdata = {13'h0000, pins};
            `SSPT_ADDR_RXD: next_rdata = {8'h00, rx_buf};
            `SSPT_ADDR_STAT: next_rdata = {7'h00, tmr_f, idle_f, rx_b9, ferr, perr, ovr, rx_full,
                                           tx_st == SSPT_TX_IDLE && !tx_full, !tx_full};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ctrl <= `SSPT_CTRL_RESET;
         baud_div <= BAUD_W'(`SSPT_BAUD_RESET);
         pins <= `SSPT_PINS_RESET;
         tx_buf <= 8'h00;
         tx_addr <= 1'b0;
         tx_full <= 1'b0;
         rx_buf <= 8'h00;
         rx_b9 <= 1'b0;
         rx_full <= 1'b0;
         ovr <= 1'b0;
         perr <= 1'b0;
         ferr <= 1'b0;
         idle_f <= 1'b0;
         tmr_f <= 1'b0;
         o_rdata <= 16'h0000;
      end else begin
         ctrl <= next_ctrl;
         baud_div <= next_baud_div;
         pins <= next_pins;
         tx_buf <= next_tx_buf;
         tx_addr <= next_tx_addr;
         tx_full <= next_tx_full;
         rx_buf <= next_rx_buf;
         rx_b9 <= next_rx_b9;
         rx_full <= next_rx_full;
         ovr <= next_ovr;
         perr <= next_perr;
         ferr <= next_ferr;
         idle_f <= next_idle_f;
         tmr_f <= next_tmr_f;
         o_rdata <= next_rdata;
      end
   end
endmodule : sspt_serial_port

// *** test/sspt_serial_port_checker.sv ***
`timescale 1ns/1ps
`include "sspt_params.svh"
// ----
// Port checker
// ----
module sspt_serial_port_checker #(
   parameter int BAUD_W = 12
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [2:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic i_rxd,
   input wire logic o_txd,
   input wire logic o_txd_oe,
   input wire logic i_sclk,
   input wire logic o_sclk,
   input wire logic o_sclk_oe,
   input wire logic o_timer_event
);
   logic [11:0] ctl, next_ctl, baud, next_baud;
   logic [2:0] pins, next_pins;
   logic master;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   // Shadow of software writes; suspend clear not tracked
   always_comb begin
      next_ctl = ctl;
      next_baud = baud;
      next_pins = pins;
      if (i_wr && i_addr == `SSPT_ADDR_CTRL) next_ctl = i_wdata[11:0];
      if (i_wr && i_addr == `SSPT_ADDR_BAUD) next_baud = i_wdata[11:0];
      if (i_wr && i_addr == `SSPT_ADDR_PINS) next_pins = i_wdata[2:0];
   end
   // Registers only
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ctl <= `SSPT_CTRL_RESET;
         baud <= `SSPT_BAUD_RESET;
         pins <= `SSPT_PINS_RESET;
      end else begin
         ctl <= next_ctl;
         baud <= next_baud;
         pins <= next_pins;
      end
   end
   assign master = pins[2] && ctl[2:0] == 3'h0 && !ctl[9] && !ctl[10];
   ctrl_readback_a: assert property (i_rd && i_addr == `SSPT_ADDR_CTRL |=>
      o_rdata[5:0] == $past(ctl[5:0]) && o_rdata[11:7] == $past(ctl[11:7])) else $error("control readback wrong");
   port_idle_a: assert property (pins == 3'h0 && $past(pins) == 3'h0 |->
      o_txd && !o_txd_oe && !o_sclk_oe) else $error("port active while all pins are gpio");
   status_cleared_a: assert property (pins == 3'h0 && $past(pins) == 3'h0 && i_rd && i_addr == `SSPT_ADDR_STAT |=>
      o_rdata[5:2] == 4'h0) else $error("status not cleared in port reset");
   sclk_drive_a: assert property (o_sclk_oe == master) else $error("serial clock drive wrong");
   wired_or_a: assert property (pins[1] && ctl[7] |-> o_txd_oe == !o_txd) else $error("line driven high");
   txd_off_a: assert property (!pins[1] |-> !o_txd_oe) else $error("txd driven while pin is gpio");
   timer_gate_a: assert property (o_timer_event |-> ctl[11]) else $error("timer event while disabled");
   timer_period_a: assert property (o_timer_event && baud == 12'h003 |=> (!o_timer_event)[*3]
      ##1 (o_timer_event || !ctl[11] || baud != 12'h003)) else $error("timer period wrong");
   async_bit_a: assert property ($fell(o_txd) && ctl[2:0] != 3'h0 && baud == 12'h000 |->
      (!o_txd)[*8] ##1 (!o_txd)[*8]) else $error("async bit shorter than sixteen ticks");
endmodule : sspt_serial_port_checker

bind sspt_serial_port sspt_serial_port_checker #(.BAUD_W(BAUD_W)) sspt_serial_port_checker_inst (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(i_rxd), .o_txd(o_txd), .o_txd_oe(o_txd_oe), .i_sclk(i_sclk),
   .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .o_timer_event(o_timer_event));

// *** test/sspt_peer_model.sv ***
`timescale 1ns/1ps
// ----
// Remote serial peer
// ----
module sspt_peer_model (
   input wire logic i_sys_clk,
   input wire logic i_line,
   input wire logic i_sclk_line,
   output logic o_rxd,
   output logic o_sclk
);
   localparam int BIT_CLKS = 16; // Divisor 0 gives one tick per clock
   // Idle: clock low, data line at mark
   initial begin
      o_rxd = 1'b1;
      o_sclk = 1'b0;
   end
   // Frame LSB first, built by the caller
   task automatic send_async(input logic [10:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         o_rxd <= bits[i];
         repeat (BIT_CLKS) @(posedge i_sys_clk);
      end
      o_rxd <= 1'b1;
   endtask : send_async
   // Mid-bit samples on the falling edge
   task automatic recv_async(input int n, output logic [10:0] bits, output logic ok);
      int t;
      bits = 11'h7FF;
      t = 0;
      while (i_line !== 1'b0 && t < 400) begin
         @(negedge i_sys_clk);
         t++;
      end
      ok = t < 400;
      repeat (BIT_CLKS / 2) @(negedge i_sys_clk);
      for (int i = 0; i < n; i++) begin
         bits[i] = i_line;
         repeat (BIT_CLKS) @(negedge i_sys_clk);
      end
   endtask : recv_async
   // Slave: sample on rise, next bit after fall
   task automatic sync_slave(input logic [7:0] tx, output logic [7:0] rx, output logic ok);
      int t;
      t = 0;
      o_rxd <= tx[0];
      for (int i = 0; i < 8; i++) begin
         while (i_sclk_line !== 1'b1 && t < 2000) begin
            @(negedge i_sys_clk);
            t++;
         end
         rx[i] = i_line;
         while (i < 7 && i_sclk_line !== 1'b0 && t < 2000) begin
            @(negedge i_sys_clk);
            t++;
         end
         if (i < 7) o_rxd <= tx[i + 1];
      end
      ok = t < 2000;
   endtask : sync_slave
   // Master of the shared clock: eight rises
   task automatic sync_master(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 0; i < 8; i++) begin
         o_rxd <= tx[i];
         repeat (8) @(posedge i_sys_clk);
         rx[i] = i_line;
         o_sclk <= 1'b1;
         repeat (8) @(posedge i_sys_clk);
         o_sclk <= 1'b0;
      end
      o_rxd <= 1'b1;
   endtask : sync_master
endmodule : sspt_peer_model

// *** test/sspt_serial_port_tb_top.sv ***
`timescale 1ns/1ps
`include "sspt_params.svh"
// ----
// Testbench
// ----
module sspt_serial_port_tb_top;
   import sspt_pkg::*;
   logic i_sys_clk, i_sys_rst, i_wr, i_rd, o_txd, o_txd_oe, o_sclk, o_sclk_oe, o_timer_event;
   logic tx_line, sclk_line, peer_rxd, peer_sclk, ok, par;
   logic [2:0] i_addr, ws;
   logic [15:0] i_wdata, o_rdata;
   logic [10:0] fr, got;
   logic [7:0] sb;
   int err_total, n_tests, nb;
   // Pull-up on data; peer never drives it; clock from the driving side
   assign tx_line = o_txd_oe ? o_txd : 1'b1;
   assign sclk_line = o_sclk_oe ? o_sclk : peer_sclk;
   sspt_serial_port sspt_serial_port_inst (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(peer_rxd), .o_txd(o_txd),
      .o_txd_oe(o_txd_oe), .i_sclk(sclk_line), .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe),
      .o_timer_event(o_timer_event));
   sspt_peer_model sspt_peer_model_inst (.i_sys_clk(i_sys_clk), .i_line(tx_line), .i_sclk_line(sclk_line),
      .o_rxd(peer_rxd), .o_sclk(peer_sclk));
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [15:0] m, input logic [15:0] exp, input string what);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      @(negedge i_sys_clk);
      chk(what, o_rdata & m, exp);
   endtask : rd
   task automatic need(input logic c);
      if (c !== 1'b1) begin
         err_total++;
         $display("Error wait bound used up");
         summarize();
      end
   endtask : need
   task automatic ticks(input logic [15:0] exp);
      int c;
      c = 0;
      repeat (40) begin
         @(negedge i_sys_clk);
         if (o_timer_event === 1'b1) c++;
      end
      chk("timer events", 16'(c), exp);
   endtask : ticks
   task automatic summarize();
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   // Hang guard
   initial begin
      repeat (90000) @(posedge i_sys_clk);
      need(1'b0);
   end
   initial begin
      {i_sys_rst, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 21'h0};
      err_total = 0;
      n_tests = 0;
      repeat (3) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      rd(`SSPT_ADDR_CTRL, 16'hFFFF, 16'h0000, "ctrl reset");
      rd(`SSPT_ADDR_BAUD, 16'hFFFF, 16'h0001, "baud reset");
      rd(`SSPT_ADDR_PINS, 16'hFFFF, 16'h0000, "pins reset");
      rd(3'h7, 16'hFFFF, 16'h0000, "unmapped");
      wr(`SSPT_ADDR_PINS, 16'h0007);
      wr(`SSPT_ADDR_BAUD, 16'h0000);
      // Each async format both ways; pass 5 via address register
      for (int f = 1; f <= 5; f++) begin
         ws = (f == 5) ? 3'h4 : f[2:0];
         sb = 8'h96 + f[7:0];
         par = (ws == 3'h2) ? ^sb : (ws == 3'h3) ? ~^sb : (f == 5);
         nb = (ws == 3'h1) ? 10 : 11;
         fr = (nb == 10) ? {2'b11, sb, 1'b0} : {1'b1, par, sb, 1'b0};
         wr(`SSPT_ADDR_CTRL, {13'h0003, ws});
         wr((f == 5) ? `SSPT_ADDR_TXA : `SSPT_ADDR_TXD, {8'h00, sb});
         sspt_peer_model_inst.recv_async(nb, got, ok);
         need(ok);
         chk("tx frame", {5'h00, got}, {5'h00, fr});
         sspt_peer_model_inst.send_async(fr, nb);
         repeat (4) @(posedge i_sys_clk);
         rd(`SSPT_ADDR_STAT, 16'h0034, 16'h0004, "rx status");
         rd(`SSPT_ADDR_RXD, 16'h00FF, {8'h00, sb}, "rx data");
      end
      // Bad even parity flagged, cleared on read
      wr(`SSPT_ADDR_CTRL, {13'h0003, SSPT_WS_EVEN});
      sspt_peer_model_inst.send_async({2'b10, 8'h5B, 1'b0}, 11);
      repeat (4) @(posedge i_sys_clk);
      rd(`SSPT_ADDR_STAT, 16'h0014, 16'h0014, "parity flag");
      rd(`SSPT_ADDR_STAT, 16'h0010, 16'h0000, "parity clear");
      rd(`SSPT_ADDR_RXD, 16'h00FF, 16'h005B, "parity data");
      // Suspended in address wakeup: data ignored, address wakes
      wr(`SSPT_ADDR_CTRL, {13'h000F, SSPT_WS_MULTI});
      sspt_peer_model_inst.send_async({2'b10, 8'h11, 1'b0}, 11);
      repeat (4) @(posedge i_sys_clk);
      rd(`SSPT_ADDR_STAT, 16'h0004, 16'h0000, "data while asleep");
      rd(`SSPT_ADDR_CTRL, 16'h0040, 16'h0040, "still asleep");
      sspt_peer_model_inst.send_async({2'b11, 8'h22, 1'b0}, 11);
      repeat (4) @(posedge i_sys_clk);
      rd(`SSPT_ADDR_STAT, 16'h0044, 16'h0044, "address char");
      rd(`SSPT_ADDR_CTRL, 16'h0040, 16'h0000, "awake on address");
      rd(`SSPT_ADDR_RXD, 16'h00FF, 16'h0022, "address data");
      // Idle-line wakeup: char discarded, idle gap wakes
      wr(`SSPT_ADDR_CTRL, {13'h000B, SSPT_WS_MULTI});
      sspt_peer_model_inst.send_async({2'b10, 8'h33, 1'b0}, 11);
      rd(`SSPT_ADDR_CTRL, 16'h0040, 16'h0040, "asleep before idle");
      repeat (200) @(posedge i_sys_clk);
      rd(`SSPT_ADDR_CTRL, 16'h0040, 16'h0000, "awake on idle");
      rd(`SSPT_ADDR_STAT, 16'h0004, 16'h0000, "asleep char dropped");
      // Wired-OR frame through the pull-up
      wr(`SSPT_ADDR_CTRL, {13'h0011, SSPT_WS_ASYNC10});
      wr(`SSPT_ADDR_TXD, 16'h003C);
      sspt_peer_model_inst.recv_async(10, got, ok);
      need(ok);
      chk("wired-or frame", {5'h00, got}, {5'h00, 2'b11, 8'h3C, 1'b0});
      // Sync master then sync slave
      wr(`SSPT_ADDR_BAUD, 16'h0007);
      wr(`SSPT_ADDR_CTRL, {13'h0003, SSPT_WS_SYNC});
      fork
         sspt_peer_model_inst.sync_slave(8'hC3, sb, ok);
         wr(`SSPT_ADDR_TXD, 16'h005A);
      join
      need(ok);
      chk("sync master tx", {8'h00, sb}, 16'h005A);
      repeat (8) @(posedge i_sys_clk);
      rd(`SSPT_ADDR_RXD, 16'h00FF, 16'h00C3, "sync master rx");
      wr(`SSPT_ADDR_CTRL, {13'h00C3, SSPT_WS_SYNC});
      wr(`SSPT_ADDR_TXD, 16'h0096);
      sspt_peer_model_inst.sync_master(8'h69, sb);
      chk("sync slave tx", {8'h00, sb}, 16'h0096);
      rd(`SSPT_ADDR_RXD, 16'h00FF, 16'h0069, "sync slave rx");
      // Port reset keeps control, clears status
      wr(`SSPT_ADDR_BAUD, 16'h0003);
      sspt_peer_model_inst.sync_master(8'hA5, sb);
      wr(`SSPT_ADDR_PINS, 16'h0000);
      rd(`SSPT_ADDR_STAT, 16'h003C, 16'h0000, "status in port reset");
      rd(`SSPT_ADDR_CTRL, 16'h0FFF, 16'h0618, "ctrl kept");
      // Timer runs without any serial pin
      wr(`SSPT_ADDR_CTRL, 16'h0800);
      ticks(16'h000A);
      wr(`SSPT_ADDR_CTRL, 16'h0000);
      ticks(16'h0000);
      summarize();
   end
endmodule : sspt_serial_port_tb_top
